// file: verilog/pmt_timer.sv
// Top of the 8-bit period match timer with its AXI4-Lite register slave.
//
// Summary of operation
// [R1] Readable writable 8-bit counter and period register.
// [R2] Run bit two enables counting, zero stops.
// [R3] Quarter clock, prescale 1, 4 or 16.
// [R4] Match divided by postscale code plus one.
// [R5] Postscaler terminal count sets sticky match flag.
// [R6] Count/control writes and reset clear scalers.
// [R7] Control write leaves count value unchanged.
// [R8] Any reset clears the counter to zero.
// [R9] Count to period, then wrap to zero.
// [R10] Reset loads period register with FFh.
// [R11] Unscaled match pulse goes to serial port.
// [R12] Count and match feed the capture/compare unit.
// [R13] Control bit seven reads zero, ignores writes.
// [R14] Stopped timer holds counters; writes still apply.
`timescale 1ns/100ps
module pmt_timer #(
    parameter int COUNT_WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output pmt_pkg::pmt_timebase_type ccp_timebase,
    output logic ssp_shift_tick,
    output logic irq
);
    import pmt_pkg::*;

    // ************************************************************
    // Elaboration check.
    // ************************************************************
    // The registers are one byte wide; the counter cannot exceed that.
    generate
        if (COUNT_WIDTH != 8) begin : g_bad_width
            $error("pmt_timer: COUNT_WIDTH must be 8");
        end
    endgenerate

    // ************************************************************
    // Register state.
    // ************************************************************
    logic [COUNT_WIDTH-1:0] timer_count; // Running count.
    logic [COUNT_WIDTH-1:0] period_limit; // Compare value for the wrap.
    logic [CTL_IMPL_MSB:0] timer_control; // Bits 6:0 only; bit 7 has no flop.
    logic match_event_flag; // Sticky flag set by the postscaler.
    logic match_event_enable; // Mask bit that lets the flag reach irq.

    // ************************************************************
    // Bus capture state.
    // ************************************************************
    logic aw_held; // Write address taken, waiting for its data.
    logic w_held; // Write data taken, waiting for its address.
    logic [4:0] wr_addr; // Captured write address.
    logic [7:0] wr_byte; // Captured low data byte.
    logic wr_lane0; // Byte lane 0 was enabled.

    // ************************************************************
    // Divider state.
    // ************************************************************
    logic [1:0] quarter_count; // Divides the core clock by four.
    logic [3:0] pre_count; // Prescaler counter.
    logic post_term; // Terminal pulse from the postscaler.

    // ************************************************************
    // Control field decode.
    // ************************************************************
    wire count_run = timer_control[CTL_COUNT_RUN];
    wire [1:0] input_divide_sel = timer_control[CTL_INPUT_DIV_MSB:CTL_INPUT_DIV_LSB];
    wire [3:0] match_divide_sel = timer_control[CTL_MATCH_DIV_MSB:CTL_MATCH_DIV_LSB];

    // Codes 1x both pick sixteen, so only the upper bit is looked at for it.
    wire [3:0] pre_last = input_divide_sel[1] ? PRE_LAST_16 :
                          input_divide_sel[0] ? PRE_LAST_4 : PRE_LAST_1; // [R3]

    // ************************************************************
    // Write decode.
    // ************************************************************
    // A write is carried out once both halves are held and no answer is pending.
    wire wr_do = aw_held && w_held && !s_axi_bvalid;
    wire wr_live = wr_do && wr_lane0;
    wire wr_count = wr_live && (wr_addr == ADDR_TIMER_COUNT);
    wire wr_period = wr_live && (wr_addr == ADDR_PERIOD_LIMIT);
    wire wr_control = wr_live && (wr_addr == ADDR_TIMER_CONTROL);
    wire wr_mask = wr_live && (wr_addr == ADDR_FLAG_MASK);
    wire wr_known = (wr_addr == ADDR_TIMER_COUNT) || (wr_addr == ADDR_PERIOD_LIMIT) ||
                    (wr_addr == ADDR_TIMER_CONTROL) || (wr_addr == ADDR_FLAG_MASK) ||
                    (wr_addr == ADDR_PERIPHERAL_FLAGS_ONE);

    // Writing the count or the control register restarts both scalers.
    wire scaler_clear = wr_count || wr_control; // [R6]

    // ************************************************************
    // Read decode.
    // ************************************************************
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire rd_is_count = (s_axi_araddr == ADDR_TIMER_COUNT);
    wire rd_is_period = (s_axi_araddr == ADDR_PERIOD_LIMIT);
    wire rd_is_control = (s_axi_araddr == ADDR_TIMER_CONTROL);
    wire rd_is_flags = (s_axi_araddr == ADDR_PERIPHERAL_FLAGS_ONE);
    wire rd_is_mask = (s_axi_araddr == ADDR_FLAG_MASK);
    wire rd_known = rd_is_count || rd_is_period || rd_is_control || rd_is_flags || rd_is_mask;
    wire [7:0] flag_byte = 8'(match_event_flag) << FLAG_MATCH_EVENT;
    wire [7:0] mask_byte = 8'(match_event_enable) << FLAG_MATCH_EVENT;

    // Bit 7 of control has no storage and is zero-extended here.
    wire [7:0] rd_byte = rd_is_count ? timer_count :
                         rd_is_period ? period_limit :
                         rd_is_control ? {1'b0, timer_control} : // [R13]
                         rd_is_flags ? flag_byte :
                         rd_is_mask ? mask_byte : 8'h00;

    // ************************************************************
    // Tick generation.
    // ************************************************************
    // Everything downstream is frozen while stopped, so no tick can leak out.
    wire inst_en = count_run && (quarter_count == QUARTER_LAST); // [R2] [R14]
    wire count_tick = inst_en && (pre_count == pre_last); // [R3]
    wire period_hit = count_tick && (timer_count == period_limit) && !wr_count; // [R9]

    // Read of the flag register clears it, but a new event in that cycle wins.
    wire flag_rd_clear = rd_take && rd_is_flags;
    wire next_flag = post_term || (match_event_flag && !flag_rd_clear); // [R5]
    wire next_mask = wr_mask ? wr_byte[FLAG_MATCH_EVENT] : match_event_enable;

    // ************************************************************
    // Quarter divider and prescaler.
    // ************************************************************
    // The quarter divider keeps its phase across writes; only the scalers restart.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quarter_count <= 2'h0;
        end else if (count_run) begin
            quarter_count <= quarter_count + 2'h1; // [R3]
        end
    end

    // Prescaler counts instruction cycles and rolls over on each tick.
    always_ff @(posedge aclk) begin
        if (!aresetn || scaler_clear) begin
            pre_count <= 4'h0; // [R6]
        end else if (count_tick) begin
            pre_count <= 4'h0; // [R3]
        end else if (inst_en) begin
            pre_count <= pre_count + 4'h1;
        end
    end

    // ************************************************************
    // Counter and period registers.
    // ************************************************************
    // A software write of the count beats a tick in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count <= COUNT_RESET; // [R8]
        end else if (wr_count) begin
            timer_count <= wr_byte; // [R1] [R14]
        end else if (period_hit) begin
            timer_count <= COUNT_ZERO; // [R9]
        end else if (count_tick) begin
            timer_count <= timer_count + 8'h01; // [R9]
        end
    end

    // Period register comes out of reset at its maximum.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_limit <= PERIOD_RESET; // [R10]
        end else if (wr_period) begin
            period_limit <= wr_byte; // [R1] [R14]
        end
    end

    // Control write stores bits 6:0 only and never touches the count.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_control <= CONTROL_RESET;
        end else if (wr_control) begin
            timer_control <= wr_byte[CTL_IMPL_MSB:0]; // [R13] [R7]
        end
    end

    // ************************************************************
    // Postscaler.
    // ************************************************************
    // Only period matches feed it, so it also holds while the timer is stopped.
    pmt_postscale #(
        .SEL_WIDTH(4)
    ) u_postscale (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(scaler_clear), // [R6]
        .match_in(period_hit), // [R4]
        .divide_sel(match_divide_sel),
        .term_out(post_term)
    );

    // ************************************************************
    // Flag, mask and interrupt.
    // ************************************************************
    // The irq flop looks at next values so it tracks the flag without lag.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_event_flag <= 1'b0;
            match_event_enable <= 1'b0;
            irq <= 1'b0;
        end else begin
            match_event_flag <= next_flag; // [R5]
            match_event_enable <= next_mask;
            irq <= next_flag && next_mask;
        end
    end

    // ************************************************************
    // Exported time base.
    // ************************************************************
    // The match pulse is taken before the postscaler and lasts one cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ssp_shift_tick <= 1'b0;
            ccp_timebase.match <= 1'b0;
        end else begin
            ssp_shift_tick <= period_hit; // [R11]
            ccp_timebase.match <= period_hit; // [R12]
        end
    end

    // The count output is the counter itself seen through the struct.
    always_comb begin
        ccp_timebase.count = timer_count; // [R12]
    end

    // ************************************************************
    // AXI4-Lite write channels.
    // ************************************************************
    // Address and data are taken independently; ready drops once each is held
    // and rises again only after the response is accepted.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wr_addr <= 5'h00;
            wr_byte <= 8'h00;
            wr_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_held && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_held && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_do) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channels.
    // ************************************************************
    // One read at a time; data are frozen in rdata so the flag clear is safe.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte}; // [R1]
            s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : pmt_timer

// file: shared/pmt_pkg.sv
// Package of constants and types for the period match timer.
package pmt_pkg;

    // ************************************************************
    // Register byte addresses on the AXI4-Lite bus.
    // ************************************************************
    localparam logic [4:0] ADDR_TIMER_COUNT = 5'h00; // Running count.
    localparam logic [4:0] ADDR_PERIOD_LIMIT = 5'h04; // Period compare value.
    localparam logic [4:0] ADDR_TIMER_CONTROL = 5'h08; // Run, prescale, postscale.
    localparam logic [4:0] ADDR_PERIPHERAL_FLAGS_ONE = 5'h0C; // Sticky event flags.
    localparam logic [4:0] ADDR_FLAG_MASK = 5'h10; // Interrupt enables.

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CTL_INPUT_DIV_LSB = 0; // Prescale select, bits 1:0.
    localparam int CTL_INPUT_DIV_MSB = 1;
    localparam int CTL_COUNT_RUN = 2; // Run bit.
    localparam int CTL_MATCH_DIV_LSB = 3; // Postscale select, bits 6:3.
    localparam int CTL_MATCH_DIV_MSB = 6;
    localparam int CTL_IMPL_MSB = 6; // Bit 7 is not implemented.
    localparam int FLAG_MATCH_EVENT = 1; // Match event flag position.

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [6:0] CONTROL_RESET = 7'h00;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

    // ************************************************************
    // Divider constants.
    // ************************************************************
    localparam logic [1:0] QUARTER_LAST = 2'h3; // Core clock divided by four.
    localparam logic [3:0] PRE_LAST_1 = 4'h0; // Prescale 1:1.
    localparam logic [3:0] PRE_LAST_4 = 4'h3; // Prescale 1:4.
    localparam logic [3:0] PRE_LAST_16 = 4'hF; // Prescale 1:16.

    // ************************************************************
    // Bus answer codes.
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Time base handed to the capture/compare unit for its PWM mode.
    typedef struct packed {
        logic [7:0] count; // Present counter value.
        logic match; // One-cycle pulse when the counter wraps on a period match.
    } pmt_timebase_type;

endpackage : pmt_pkg

// file: verilog/pmt_postscale.sv
// Postscaler that divides the period match pulse by one to sixteen.
`timescale 1ns/100ps
module pmt_postscale #(
    parameter int SEL_WIDTH = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic match_in,
    input wire logic [SEL_WIDTH-1:0] divide_sel,
    output logic term_out
);

    // ************************************************************
    // Elaboration check.
    // ************************************************************
    generate
        if (SEL_WIDTH < 1 || SEL_WIDTH > 8) begin : g_bad_width
            $error("pmt_postscale: SEL_WIDTH must lie between 1 and 8");
        end
    endgenerate

    logic [SEL_WIDTH-1:0] post_count; // Matches seen since the last terminal count.
    wire at_last = (post_count == divide_sel); // Select code N means divide by N+1.

    // Counts matches; the terminal pulse is a flop so the flag sees a clean edge.
    // A clear beats a match in the same cycle, so a restart always begins at zero.
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            post_count <= '0; // [R6]
            term_out <= 1'b0;
        end else if (match_in) begin
            post_count <= at_last ? '0 : post_count + 1'b1; // [R4]
            term_out <= at_last; // [R4]
        end else begin
            term_out <= 1'b0;
        end
    end

endmodule : pmt_postscale

// file: tb/pmt_timer_asserts.sv
// Concurrent checks on the ports of the period match timer.
`timescale 1ns/100ps
module pmt_timer_asserts #(
    parameter int COUNT_WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire pmt_pkg::pmt_timebase_type ccp_timebase,
    input wire logic ssp_shift_tick,
    input wire logic irq
);
    import pmt_pkg::*;

    // All checks share the bus clock and are quiet while reset is held.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // Time base and interrupt.
    // ****************************************************************
    ssp_equal_a: assert property (ssp_shift_tick == ccp_timebase.match)
        else $error("serial tick and time base match disagree");
    tick_width_a: assert property (ssp_shift_tick |=> !ssp_shift_tick)
        else $error("match pulse longer than one cycle");
    wrap_zero_a: assert property (ssp_shift_tick |-> ccp_timebase.count == COUNT_ZERO)
        else $error("match pulse without a wrapped counter");
    // The counter only steps by one or wraps, unless a bus write lands.
    count_step_a: assert property (!$rose(s_axi_bvalid) && $changed(ccp_timebase.count)
        |-> ccp_timebase.count == $past(ccp_timebase.count) + 1'b1
        || ccp_timebase.count == COUNT_ZERO)
        else $error("counter moved by other than one");
    // The postscaler pulse leaves with the match pulse, so the flag follows it by one edge.
    irq_cause_a: assert property ($rose(irq) |-> $past(ssp_shift_tick)
        || $rose(s_axi_bvalid) || ($past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)))
        else $error("interrupt rose without a match");
    irq_clear_a: assert property ($fell(irq)
        |-> s_axi_rvalid || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt dropped without software access");

    // ****************************************************************
    // Register bus.
    // ****************************************************************
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    read_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above byte zero");

    cover property (ssp_shift_tick);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : pmt_timer_asserts

// file: tb/pmt_peer_model.sv
// Model of the serial port and capture/compare unit that use the match pulse.
`timescale 1ns/100ps
module pmt_peer_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pmt_pkg::pmt_timebase_type ccp_timebase,
    input wire logic ssp_shift_tick,
    output int tick_count,
    output int mismatch_count
);
    import pmt_pkg::*;

    // Each pulse is one shift clock edge; the PWM time base must see the same pulse.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_count <= 0;
            mismatch_count <= 0;
        end else begin
            if (ssp_shift_tick === 1'b1) begin
                tick_count <= tick_count + 1;
            end
            if (ccp_timebase.match !== ssp_shift_tick) begin
                mismatch_count <= mismatch_count + 1;
            end
        end
    end
endmodule : pmt_peer_model

// file: tb/pmt_timer_test.sv
// Register-level testbench of the period match timer.
`timescale 1ns/100ps
module pmt_timer_test;
    import pmt_pkg::*;

    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, ssp_shift_tick, irq;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    pmt_timebase_type ccp_timebase;
    int tick_count, mismatch_count, fail_count, n_checks, cycles;

    pmt_timer #(.COUNT_WIDTH(8)) i_pmt_timer (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ccp_timebase(ccp_timebase), .ssp_shift_tick(ssp_shift_tick), .irq(irq));

    pmt_peer_model i_pmt_peer_model (.*);

    // Free-running 20 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Watchdog: the whole run needs a few thousand cycles, so a hang ends here.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    // Compares one value and records any mismatch.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Bus write: address and data offered together, each released once taken.
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    // Bus read, compared with the expected word and response.
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        s_axi_rready <= 1'b0;
        chk($sformatf("read %h", a), s_axi_rdata, e);
        chk($sformatf("rresp %h", a), {30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    // Cycles between two successive match pulses.
    task automatic pulse_gap(output int g);
        g = 0;
        @(posedge aclk iff ssp_shift_tick === 1'b1);
        do begin
            @(posedge aclk);
            g++;
        end while (ssp_shift_tick !== 1'b1);
    endtask : pulse_gap

    // Waits for the interrupt, notes the match count, then clears the flag by reading.
    task automatic wait_flag(output int t);
        @(posedge aclk iff irq === 1'b1);
        t = tick_count;
        rd(ADDR_PERIPHERAL_FLAGS_ONE, 32'h2);
    endtask : wait_flag

    task summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        int g, t0, t1;
        int codes[3] = '{0, 3, 15};
        aresetn <= 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        s_axi_awaddr <= 5'h00;
        s_axi_araddr <= 5'h00;
        s_axi_wdata <= 32'h00000000;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_TIMER_COUNT, 32'h00);
        rd(ADDR_PERIOD_LIMIT, 32'hFF);
        rd(ADDR_TIMER_CONTROL, 32'h00);
        rd(ADDR_PERIPHERAL_FLAGS_ONE, 32'h00);
        rd(ADDR_FLAG_MASK, 32'h00);
        // Every prescale code with a short period; the gap is 4 * prescale * 3.
        wr(ADDR_PERIOD_LIMIT, 8'h02);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_TIMER_CONTROL, 8'h04 | 8'(s));
            pulse_gap(g);
            chk("match gap", 32'(g), 32'(12 * (s == 0 ? 1 : (s == 1 ? 4 : 16))));
        end
        // Postscale codes: the flag comes once per code plus one matches.
        wr(ADDR_PERIOD_LIMIT, 8'h07);
        rd(ADDR_PERIOD_LIMIT, 32'h07);
        wr(ADDR_FLAG_MASK, 8'h02);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_TIMER_CONTROL, 8'(codes[i] << 3) | 8'h04);
            wait_flag(t0);
            wait_flag(t0);
            wait_flag(t1);
            chk("post gap", 32'(t1 - t0), 32'(codes[i] + 1));
        end
        // A count write half way through a divide-by-two restarts the postscaler.
        wr(ADDR_TIMER_CONTROL, 8'h0C);
        wait_flag(t0);
        wait_flag(t0);
        @(posedge aclk iff ssp_shift_tick === 1'b1);
        wr(ADDR_TIMER_COUNT, 8'h00);
        wait_flag(t1);
        chk("clear gap", 32'(t1 - t0), 32'h3);
        // Masked flag keeps the interrupt low but stays latched until read.
        wr(ADDR_FLAG_MASK, 8'h00);
        repeat (100) @(posedge aclk);
        chk("irq masked", 32'(irq), 32'h0);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        repeat (10) @(posedge aclk);
        rd(ADDR_PERIPHERAL_FLAGS_ONE, 32'h2);
        rd(ADDR_PERIPHERAL_FLAGS_ONE, 32'h0);
        // Stopped timer: writes apply, count holds, bit seven ignored.
        wr(ADDR_TIMER_COUNT, 8'h33);
        repeat (50) @(posedge aclk);
        rd(ADDR_TIMER_COUNT, 32'h33);
        wr(ADDR_TIMER_CONTROL, 8'hFB);
        rd(ADDR_TIMER_CONTROL, 32'h7B);
        rd(ADDR_TIMER_COUNT, 32'h33);
        wr(5'h14, 8'h55, RESP_SLVERR);
        rd(5'h14, 32'h00, RESP_SLVERR);
        chk("time base", 32'(mismatch_count), 32'h0);
        summarize();
    end
endmodule : pmt_timer_test

bind pmt_timer pmt_timer_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) i_pmt_timer_asserts (.*);
